// ### design/aosc_pkg.sv
package aosc_pkg;
  // Channel count and data widths
  localparam int NCH = 4;
  localparam int DW = 16;
  localparam int AW = 9;

  // Clock rate and the one-second base of the hold timer
  localparam longint CLK_HZ = 64'd10_000_000;
  localparam longint SEC_MS = 64'd1000;
  localparam longint SEC_CYCLES = CLK_HZ * SEC_MS / 64'd1000;

  // Per-channel block: stride and word offsets inside it
  localparam logic [AW-1:0] CH_STRIDE = 9'h020;
  localparam logic [4:0] OFS_CFG = 5'h00;
  localparam logic [4:0] OFS_RUN = 5'h04;
  localparam logic [4:0] OFS_FLT = 5'h08;
  localparam logic [4:0] OFS_PRG = 5'h0c;
  localparam logic [4:0] OFS_FIN = 5'h10;
  localparam logic [4:0] OFS_STA = 5'h14;
  localparam logic [AW-1:0] CH_END = 9'h080;

  // Global registers
  localparam logic [AW-1:0] ADR_IRQ_STS = 9'h100;
  localparam logic [AW-1:0] ADR_IRQ_MSK = 9'h104;
  localparam logic [AW-1:0] ADR_UNLATCH = 9'h108;

  // Configuration word fields
  localparam int F_RANGE = 0;
  localparam int F_ALM_OFF = 4;
  localparam int F_LIM_LAT = 5;
  localparam int F_SLW_LAT = 6;
  localparam int F_OPEN_LD = 7;
  localparam int F_CH_OFF = 8;
  localparam int F_FLT_ACT = 9;
  localparam int F_PRG_ACT = 10;
  localparam int F_P2F = 11;
  localparam int F_HOLD = 12;
  localparam int CFG_W = 16;
  localparam logic [CFG_W-1:0] CFG_RST = 16'h0610;

  // Status bit groups in the interrupt registers
  localparam int EV_LIM = 0;
  localparam int EV_SLW = 4;
  localparam int EV_OPEN = 8;
  localparam int EV_FLT = 12;
  localparam int EV_W = 16;

  // Range codes
  localparam logic [2:0] RNG_PM10V = 3'h0;
  localparam logic [2:0] RNG_0_5V = 3'h1;
  localparam logic [2:0] RNG_0_10V = 3'h2;
  localparam logic [2:0] RNG_0_20MA = 3'h4;
  localparam logic [2:0] RNG_4_20MA = 3'h5;
  // Live zero of 4-20 mA as a fraction of full scale
  localparam logic [DW-1:0] LIVE_ZERO = 16'h3333;
  localparam logic [DW-1:0] MID_CODE = 16'h8000;

  // Fault hold duration codes
  localparam logic [3:0] HOLD_FOREVER = 4'h0;
  localparam logic [3:0] HOLD_1S = 4'h1;
  localparam logic [3:0] HOLD_2S = 4'h2;
  localparam logic [3:0] HOLD_5S = 4'h5;
  localparam logic [3:0] HOLD_10S = 4'ha;

  // Channel safe-state machine, Gray coded along run-hold-final
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_HOLD = 2'h1,
    ST_FINAL = 2'h3,
    ST_PROG = 2'h2
  } aosc_state_t;
endpackage

// ### design/aosc_tick.sv
`timescale 1ns/1ps
`default_nettype none
// One-cycle pulse every DIV clocks
module aosc_tick #(
  parameter int DIV = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Enable pulse out
  output logic tick
);
  logic [31:0] cnt_r; // Cycles since last pulse

  // Free-running divider
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end
    else if (cnt_r == 32'(DIV - 1))
    begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // aosc_tick
`default_nettype wire

// ### design/aosc_top.sv
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module aosc_top #(
  parameter longint SEC_CYC = aosc_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [aosc_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Connection state from the host link
  input wire logic conn_fault,
  input wire logic prog_mode,
  // Alarm and diagnostic causes per channel
  input wire logic [aosc_pkg::NCH-1:0] limit_cond,
  input wire logic [aosc_pkg::NCH-1:0] slew_cond,
  input wire logic [aosc_pkg::NCH-1:0] open_load_det,
  // Converter side per channel
  output logic [aosc_pkg::NCH-1:0][aosc_pkg::DW-1:0] out_code,
  output logic [aosc_pkg::NCH-1:0][2:0] out_span,
  output logic [aosc_pkg::NCH-1:0] out_enable,
  output logic [aosc_pkg::NCH-1:0] open_load_run,
  output logic [aosc_pkg::NCH-1:0] limit_alarm,
  output logic [aosc_pkg::NCH-1:0] slew_alarm,
  // Interrupt
  output logic irq
);
  localparam int N = aosc_pkg::NCH;
  localparam int W = aosc_pkg::DW;

  // Per-channel storage
  logic [aosc_pkg::CFG_W-1:0] cfg_r [N]; // Configuration words
  logic [W-1:0] run_val_r [N]; // Values from the controller
  logic [W-1:0] flt_val_r [N]; // Fault action value
  logic [W-1:0] prg_val_r [N]; // Program value
  logic [W-1:0] fin_val_r [N]; // Final fault value
  aosc_pkg::aosc_state_t st_r [N]; // Safe-state machines
  logic [3:0] sec_r [N]; // Seconds spent in fault hold
  logic [aosc_pkg::EV_W-1:0] sts_r; // Sticky events
  logic [aosc_pkg::EV_W-1:0] msk_r; // Interrupt mask
  logic ack_r; // Second cycle of a bus access
  logic tick; // One-second pulse
  logic wr_go; // Write commits this edge
  logic [aosc_pkg::EV_W-1:0] ev; // Events this cycle
  logic [aosc_pkg::NCH-1:0] unl_lim; // Limit unlatch strobes
  logic [aosc_pkg::NCH-1:0] unl_slw; // Slew unlatch strobes

  // Channel index of a per-channel address, N when global
  function automatic int ch_of(input logic [aosc_pkg::AW-1:0] a);
    if (a < aosc_pkg::CH_END)
      return int'(a / aosc_pkg::CH_STRIDE);
    return N;
  endfunction

  // Word offset inside a channel block
  function automatic logic [4:0] ofs_of(input logic [aosc_pkg::AW-1:0] a);
    return a[4:0];
  endfunction

  // Seconds for a hold code; unknown codes hold forever
  function automatic logic [3:0] hold_secs(input logic [3:0] c);
    case (c)
      aosc_pkg::HOLD_1S: return 4'h1;
      aosc_pkg::HOLD_2S: return 4'h2;
      aosc_pkg::HOLD_5S: return 4'h5;
      aosc_pkg::HOLD_10S: return 4'ha;
      default: return 4'h0;
    endcase
  endfunction

  // Range code is one of the supported spans
  function automatic logic rng_ok(input logic [2:0] r);
    case (r)
      aosc_pkg::RNG_PM10V, aosc_pkg::RNG_0_5V, aosc_pkg::RNG_0_10V,
      aosc_pkg::RNG_0_20MA, aosc_pkg::RNG_4_20MA: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Channel off, or unsupported range, parks the output
  function automatic logic ch_dis(input logic [aosc_pkg::CFG_W-1:0] c);
    return c[aosc_pkg::F_CH_OFF] | ~rng_ok(c[aosc_pkg::F_RANGE +: 3]);
  endfunction

  // Live-zero span never goes below 4 mA on a live channel; judged on the new value,
  // since judging the old register would toggle every cycle
  function automatic logic [W-1:0] lz_clamp(
    input logic [aosc_pkg::CFG_W-1:0] c, input logic [W-1:0] v);
    if (c[aosc_pkg::F_RANGE +: 3] == aosc_pkg::RNG_4_20MA &&
        v < aosc_pkg::LIVE_ZERO)
      return aosc_pkg::LIVE_ZERO;
    return v;
  endfunction

  // Second base for fault hold timing
  aosc_tick #(
    .DIV(int'(SEC_CYC))
  ) u_sec (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick)
  );

  // Bus answers one cycle after the request
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go = avs_write & ack_r;

  // Access phase tracker
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  // Register writes; unmapped addresses are dropped
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < N; i++)
      begin
        cfg_r[i] <= aosc_pkg::CFG_RST;
        run_val_r[i] <= 16'h0000;
        flt_val_r[i] <= 16'h0000;
        prg_val_r[i] <= 16'h0000;
        fin_val_r[i] <= 16'h0000;
      end
      msk_r <= 16'h0000;
    end
    else if (wr_go)
    begin
      if (ch_of(avs_address) < N)
      begin
        case (ofs_of(avs_address))
          aosc_pkg::OFS_CFG:
            cfg_r[ch_of(avs_address)] <= avs_writedata[aosc_pkg::CFG_W-1:0];
          aosc_pkg::OFS_RUN:
            run_val_r[ch_of(avs_address)] <= avs_writedata[W-1:0];
          aosc_pkg::OFS_FLT:
            flt_val_r[ch_of(avs_address)] <= avs_writedata[W-1:0];
          aosc_pkg::OFS_PRG:
            prg_val_r[ch_of(avs_address)] <= avs_writedata[W-1:0];
          aosc_pkg::OFS_FIN:
            fin_val_r[ch_of(avs_address)] <= avs_writedata[W-1:0];
          default: ;
        endcase
      end
      else if (avs_address == aosc_pkg::ADR_IRQ_MSK)
        msk_r <= avs_writedata[aosc_pkg::EV_W-1:0];
    end
  end

  // Unlatch strobes, one cycle, from the unlatch register
  assign unl_lim = (wr_go && avs_address == aosc_pkg::ADR_UNLATCH) ?
    avs_writedata[N-1:0] : '0;
  assign unl_slw = (wr_go && avs_address == aosc_pkg::ADR_UNLATCH) ?
    avs_writedata[2*N-1:N] : '0;

  // Read data captured in the wait cycle, held to the answer edge
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      avs_readdata <= 32'h0;
    else if (avs_read & ~ack_r)
    begin
      avs_readdata <= 32'h0;
      if (ch_of(avs_address) < N)
      begin
        case (ofs_of(avs_address))
          aosc_pkg::OFS_CFG:
            avs_readdata <= 32'(cfg_r[ch_of(avs_address)]);
          aosc_pkg::OFS_RUN:
            avs_readdata <= 32'(run_val_r[ch_of(avs_address)]);
          aosc_pkg::OFS_FLT:
            avs_readdata <= 32'(flt_val_r[ch_of(avs_address)]);
          aosc_pkg::OFS_PRG:
            avs_readdata <= 32'(prg_val_r[ch_of(avs_address)]);
          aosc_pkg::OFS_FIN:
            avs_readdata <= 32'(fin_val_r[ch_of(avs_address)]);
          aosc_pkg::OFS_STA:
            avs_readdata <= {24'h0, sec_r[ch_of(avs_address)],
              slew_alarm[ch_of(avs_address)],
              limit_alarm[ch_of(avs_address)],
              st_r[ch_of(avs_address)]};
          default: ;
        endcase
      end
      else if (avs_address == aosc_pkg::ADR_IRQ_STS)
        avs_readdata <= 32'(sts_r);
      else if (avs_address == aosc_pkg::ADR_IRQ_MSK)
        avs_readdata <= 32'(msk_r);
    end
  end

  // Alarm states per channel
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      limit_alarm <= '0;
      slew_alarm <= '0;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (cfg_r[i][aosc_pkg::F_ALM_OFF] || ch_dis(cfg_r[i]))
        begin
          // Suppressed: nothing raises, stale latches drop
          limit_alarm[i] <= 1'b0;
          slew_alarm[i] <= 1'b0;
        end
        else
        begin
          // Latched alarms survive the cause; a new cause beats unlatch
          if (cfg_r[i][aosc_pkg::F_LIM_LAT])
            limit_alarm[i] <= limit_cond[i] |
              (limit_alarm[i] & ~unl_lim[i]);
          else
            limit_alarm[i] <= limit_cond[i];
          if (cfg_r[i][aosc_pkg::F_SLW_LAT])
            slew_alarm[i] <= slew_cond[i] |
              (slew_alarm[i] & ~unl_slw[i]);
          else
            slew_alarm[i] <= slew_cond[i];
        end
      end
    end
  end

  // Diagnostic runs only where enabled on a live channel
  always_comb
  begin
    for (int i = 0; i < N; i++)
      open_load_run[i] = cfg_r[i][aosc_pkg::F_OPEN_LD] &
        ~ch_dis(cfg_r[i]);
  end

  // Events: alarm rising, open load seen, fault hold entered
  always_comb
  begin
    ev = '0;
    for (int i = 0; i < N; i++)
    begin
      ev[aosc_pkg::EV_LIM + i] = limit_cond[i] & ~limit_alarm[i] &
        ~cfg_r[i][aosc_pkg::F_ALM_OFF] & ~ch_dis(cfg_r[i]);
      ev[aosc_pkg::EV_SLW + i] = slew_cond[i] & ~slew_alarm[i] &
        ~cfg_r[i][aosc_pkg::F_ALM_OFF] & ~ch_dis(cfg_r[i]);
      ev[aosc_pkg::EV_OPEN + i] = open_load_det[i] & open_load_run[i];
      ev[aosc_pkg::EV_FLT + i] = conn_fault & ~ch_dis(cfg_r[i]) &
        (st_r[i] == aosc_pkg::ST_RUN ||
         (st_r[i] == aosc_pkg::ST_PROG && cfg_r[i][aosc_pkg::F_P2F]));
    end
  end

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      sts_r <= '0;
    else if (wr_go && avs_address == aosc_pkg::ADR_IRQ_STS)
      sts_r <= (sts_r & ~avs_writedata[aosc_pkg::EV_W-1:0]) | ev;
    else
      sts_r <= sts_r | ev;
  end

  assign irq = |(sts_r & msk_r);

  // Safe-state machine and hold timer per channel
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < N; i++)
      begin
        st_r[i] <= aosc_pkg::ST_RUN;
        sec_r[i] <= 4'h0;
      end
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        case (st_r[i])
          aosc_pkg::ST_RUN:
          begin
            sec_r[i] <= 4'h0;
            if (conn_fault)
              st_r[i] <= aosc_pkg::ST_HOLD;
            else if (prog_mode)
              st_r[i] <= aosc_pkg::ST_PROG;
          end
          aosc_pkg::ST_PROG:
          begin
            sec_r[i] <= 4'h0;
            // Without the select a fault leaves the channel here
            if (conn_fault && cfg_r[i][aosc_pkg::F_P2F])
              st_r[i] <= aosc_pkg::ST_HOLD;
            else if (!conn_fault && !prog_mode)
              st_r[i] <= aosc_pkg::ST_RUN;
          end
          aosc_pkg::ST_HOLD:
          begin
            // Counts whole seconds; first one may be short by nearly a whole second
            if (!conn_fault)
              st_r[i] <= prog_mode ? aosc_pkg::ST_PROG : aosc_pkg::ST_RUN;
            else if (hold_secs(cfg_r[i][aosc_pkg::F_HOLD +: 4]) != 4'h0 &&
                     tick && sec_r[i] + 4'h1 ==
                     hold_secs(cfg_r[i][aosc_pkg::F_HOLD +: 4]))
              st_r[i] <= aosc_pkg::ST_FINAL;
            else if (tick &&
                     hold_secs(cfg_r[i][aosc_pkg::F_HOLD +: 4]) != 4'h0)
              sec_r[i] <= sec_r[i] + 4'h1;
          end
          aosc_pkg::ST_FINAL:
          begin
            if (!conn_fault)
              st_r[i] <= prog_mode ? aosc_pkg::ST_PROG : aosc_pkg::ST_RUN;
          end
          default:
            st_r[i] <= aosc_pkg::ST_RUN;
        endcase
      end
    end
  end

  // Output value, enable and span per channel
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      out_code <= '0;
      out_span <= '0;
      out_enable <= '0;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        out_span[i] <= cfg_r[i][aosc_pkg::F_RANGE +: 3];
        out_enable[i] <= ~ch_dis(cfg_r[i]);
        if (ch_dis(cfg_r[i]))
          // Parked at span zero so nothing drives the load
          out_code[i] <= (cfg_r[i][aosc_pkg::F_RANGE +: 3] ==
            aosc_pkg::RNG_PM10V) ? aosc_pkg::MID_CODE : 16'h0000;
        else
        begin
          case (st_r[i])
            aosc_pkg::ST_RUN:
              out_code[i] <= lz_clamp(cfg_r[i], run_val_r[i]);
            aosc_pkg::ST_PROG:
              // Final value never used here, fault or not
              if (!cfg_r[i][aosc_pkg::F_PRG_ACT])
                out_code[i] <= lz_clamp(cfg_r[i], prg_val_r[i]);
            aosc_pkg::ST_HOLD:
              // Held codes keep the clamp they got when last set
              if (!cfg_r[i][aosc_pkg::F_FLT_ACT])
                out_code[i] <= lz_clamp(cfg_r[i], flt_val_r[i]);
            aosc_pkg::ST_FINAL:
              out_code[i] <= lz_clamp(cfg_r[i], fin_val_r[i]);
            default: ;
          endcase
        end
      end
    end
  end
endmodule // aosc_top
`default_nettype wire

// ### verification/aosc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module aosc_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Link state
  input wire logic conn_fault,
  input wire logic prog_mode,
  // Causes
  input wire logic [aosc_pkg::NCH-1:0] limit_cond,
  input wire logic [aosc_pkg::NCH-1:0] slew_cond,
  // Converter side
  input wire logic [aosc_pkg::NCH-1:0][aosc_pkg::DW-1:0] out_code,
  input wire logic [aosc_pkg::NCH-1:0][2:0] out_span,
  input wire logic [aosc_pkg::NCH-1:0] out_enable,
  input wire logic [aosc_pkg::NCH-1:0] limit_alarm,
  input wire logic [aosc_pkg::NCH-1:0] slew_alarm,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Request still waiting
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Calm stretch, long enough to cover the output pipeline
  sequence s_calm;
    (!conn_fault && !avs_write && $stable(prog_mode))[*4];
  endsequence
  wait_one_a: assert property (s_req |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  irq_sticky_a: assert property (irq && !avs_write |=> irq)
    else $error("irq dropped without write");
  span_legal_a: assert property (out_enable[1] |->
    out_span[1] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
    else $error("live channel with bad span");
  limit_cause_a: assert property ($rose(limit_alarm[0]) |->
    $past(limit_cond[0]) || $past(limit_cond[0], 2))
    else $error("limit alarm without cause");
  slew_cause_a: assert property ($rose(slew_alarm[0]) |->
    $past(slew_cond[0]) || $past(slew_cond[0], 2))
    else $error("slew alarm without cause");
  calm_out_a: assert property (s_calm |=> $stable(out_code))
    else $error("output moved while calm");
endmodule // aosc_checker
bind aosc_top aosc_checker chk_i (.sys_clk, .rst, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .conn_fault, .prog_mode, .limit_cond,
  .slew_cond, .out_code, .out_span, .out_enable, .limit_alarm,
  .slew_alarm, .irq);
`default_nettype wire

// ### verification/aosc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host link: follows requested state after a lag of some cycles
module aosc_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Wanted state and reaction lag
  input wire logic go_fault,
  input wire logic go_prog,
  input wire logic [3:0] lag,
  // Link state to the block
  output logic conn_fault,
  output logic prog_mode
);
  logic [3:0] cnt_r; // Lag counter
  // Slow hosts change state late, never early
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      conn_fault <= 1'b0;
      prog_mode <= 1'b0;
      cnt_r <= 4'h0;
    end
    else if ({go_fault, go_prog} != {conn_fault, prog_mode})
    begin
      if (cnt_r >= lag)
      begin
        conn_fault <= go_fault;
        prog_mode <= go_prog;
        cnt_r <= 4'h0;
      end
      else
        cnt_r <= cnt_r + 4'h1;
    end
    else
      cnt_r <= 4'h0;
  end
endmodule // aosc_host_model
`default_nettype wire

// ### verification/aosc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aosc_top_tb;
  logic sys_clk = 1'b0, rst = 1'b1;
  logic [aosc_pkg::AW-1:0] avs_address = '0;
  logic avs_read = 1'b0, avs_write = 1'b0, irq, avs_waitrequest;
  logic [31:0] avs_writedata = '0, avs_readdata;
  logic conn_fault, prog_mode, go_fault = 1'b0, go_prog = 1'b0;
  logic [3:0] lag = 4'h0, limit_cond = '0, slew_cond = '0;
  logic [3:0] open_load_det = '0, out_enable, open_load_run;
  logic [3:0] limit_alarm, slew_alarm;
  logic [3:0][15:0] out_code;
  logic [3:0][2:0] out_span;
  int err_count = 0, num_checks = 0;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  logic [15:0] seed = 16'h14c4;
  logic [15:0] v[5]; // Run, fault, program, final, run of channel 2
  logic [15:0] lz_exp; // Expected code of channel 1 per span
  logic [2:0] rng[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
  int hold[4] = '{1, 2, 5, 10};
  // Clock
  initial forever #50 sys_clk = ~sys_clk;
  aosc_top #(.SEC_CYC(20)) dut (.sys_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .conn_fault, .prog_mode, .limit_cond, .slew_cond, .open_load_det,
    .out_code, .out_span, .out_enable, .open_load_run, .limit_alarm,
    .slew_alarm, .irq);
  aosc_host_model host (.sys_clk, .rst, .go_fault, .go_prog, .lag,
    .conn_fault, .prog_mode);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [8:0] ca(input logic [1:0] c, input logic [4:0] o);
    return {2'h0, c, o};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // Only the watchdog ends a wait that never answers
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Wait for the host to follow, then for state and output
  // One edge first so the new wanted state is visible to the compare
  task automatic settle;
    @(posedge sys_clk);
    while ({conn_fault, prog_mode} !== {go_fault, go_prog})
      @(posedge sys_clk);
    cyc(4);
  endtask
  // Read result watcher
  always @(posedge sys_clk)
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      chk("rdata", exp_q.pop_front(), avs_readdata);
  // Watchdog
  initial
  begin
    cyc(5000);
    err_count++;
    final_report;
  end
  // Main sequence
  initial
  begin
    cyc(10);
    rst <= 1'b0;
    rd(ca(0, aosc_pkg::OFS_CFG), 32'h0610);
    rd(9'h1fc, 32'h0);
    rd(aosc_pkg::ADR_UNLATCH, 32'h0);
    chk("olr", 4'h0, open_load_run);
    for (int i = 0; i < 6; i++)
    begin
      wr(ca(1, aosc_pkg::OFS_CFG), {29'h16, rng[i]});
      cyc(3);
      chk("span", rng[i], out_span[1]);
      chk("en", rng[i] != 3'h3, out_enable[1]);
      chk("olr", {2'h0, rng[i] != 3'h3, 1'b0}, open_load_run);
      lz_exp = (rng[i] == aosc_pkg::RNG_4_20MA) ? aosc_pkg::LIVE_ZERO : 16'h0;
      chk("code1", lz_exp, out_code[1]);
    end
    wr(ca(1, aosc_pkg::OFS_CFG), 32'h0780);
    cyc(3);
    chk("en", 1'b0, out_enable[1]);
    chk("olr", 4'h0, open_load_run);
    chk("code1", aosc_pkg::MID_CODE, out_code[1]);
    // Latched alarms on channel 0, then suppressed
    wr(ca(0, aosc_pkg::OFS_CFG), 32'h0660);
    limit_cond <= 4'h1;
    slew_cond <= 4'h1;
    open_load_det <= seed[3:0];
    cyc(3);
    limit_cond <= 4'h0;
    slew_cond <= 4'h0;
    cyc(3);
    chk("lim", 4'h1, limit_alarm);
    chk("slw", 4'h1, slew_alarm);
    wr(aosc_pkg::ADR_UNLATCH, 32'h11);
    cyc(3);
    chk("lim", 4'h0, limit_alarm);
    chk("slw", 4'h0, slew_alarm);
    wr(ca(0, aosc_pkg::OFS_CFG), 32'h0670);
    limit_cond <= 4'h1;
    slew_cond <= 4'h1;
    cyc(3);
    chk("lim", 4'h0, limit_alarm);
    chk("slw", 4'h0, slew_alarm);
    limit_cond <= 4'h0;
    slew_cond <= 4'h0;
    // Values for run, fault, program and final outputs
    for (int k = 0; k < 5; k++)
    begin
      seed = lfsr(seed);
      v[k] = seed;
    end
    for (int k = 0; k < 4; k++)
      wr(ca(0, 5'(4 * k + 4)), {16'h0, v[k]});
    wr(ca(2, aosc_pkg::OFS_RUN), {16'h0, v[4]});
    wr(ca(2, aosc_pkg::OFS_FIN), {16'h0, v[3]});
    wr(ca(0, aosc_pkg::OFS_CFG), 32'h1000);
    cyc(3);
    chk("out0", v[0], out_code[0]);
    go_prog <= 1'b1;
    settle;
    chk("out0", v[2], out_code[0]);
    chk("out2", v[4], out_code[2]);
    go_fault <= 1'b1;
    settle;
    cyc(30);
    chk("out0", v[2], out_code[0]);
    go_fault <= 1'b0;
    go_prog <= 1'b0;
    settle;
    chk("out0", v[0], out_code[0]);
    wr(aosc_pkg::ADR_IRQ_MSK, 32'h1000);
    for (int h = 0; h < 4; h++)
    begin
      wr(ca(0, aosc_pkg::OFS_CFG), 32'(hold[h]) << 12);
      go_fault <= 1'b1;
      lag <= 4'(hold[h]);
      settle;
      if (h > 0) chk("out0", v[1], out_code[0]);
      chk("irq", 1'b1, irq);
      cyc(20 * hold[h]);
      chk("out0", v[3], out_code[0]);
      chk("out2", v[4], out_code[2]);
      wr(aosc_pkg::ADR_IRQ_STS, 32'h1000);
      cyc(1);
      chk("irq", 1'b0, irq);
      go_fault <= 1'b0;
      settle;
    end
    wr(ca(0, aosc_pkg::OFS_CFG), 32'h0800);
    go_prog <= 1'b1;
    settle;
    go_fault <= 1'b1;
    settle;
    chk("out0", v[1], out_code[0]);
    final_report;
  end
endmodule // aosc_top_tb
`default_nettype wire
